// File: hw/mrc_defines.svh
// Bit positions, codes and timing counts for the mode register three block.
// Assumes a 50 MHz core clock and a controller clock sampled on pins.
// Functional notes
// - During writes, termination switches to write value from register two unless that value is off.
// - In write leveling only nominal termination applies.
// - With write CRC on, write bursts are 10 UI instead of 8.
// - Mode-set with select bits 20:18 = 011 loads register three.
// - Bits 12:11 pick readout format: serial, parallel, staggered.
// - Bits 10:9 give CRC/mask write latency of 4, 5 or 6 clocks.
// - Bits 8:6 select fixed or on-the-fly refresh granularity.
// - Bit 5 keeps temperature status in page 2 location zero bits 4:3.
// - Temperature status read back is never older than 32 ms.
// - Bit 4 enables per-device addressing of commands.
// - Bit 3 selects 1:1 or 2:1 gear-down clock ratio.
// - Bit 2 redirects all reads to the pattern readout store.
// - Bits 1:0 select page 0 to 3; page 3 is restricted.
// - Read address picks location and upper or lower half.
// - Reset is accepted in readout mode; full init follows.
// - Store gives register readout, patterns and parity error frame.
// - Write termination decodes off, 120, 240, high-Z, 80 ohm.
// - Register two bit 12 enables write data CRC.
`ifndef MRC_DEFINES_SVH
`define MRC_DEFINES_SVH
`define MRC_SEL_MR2     3'h2
`define MRC_SEL_MR3     3'h3
`define MRC_FMT_HI      12
`define MRC_FMT_LO      11
`define MRC_WCL_HI      10
`define MRC_WCL_LO      9
`define MRC_FGR_HI      8
`define MRC_FGR_LO      6
`define MRC_TEMP_EN     5
`define MRC_PDA_EN      4
`define MRC_GEAR        3
`define MRC_MPR_EN      2
`define MRC_PAGE_HI     1
`define MRC_PAGE_LO     0
`define MRC_CRC_EN      12
`define MRC_WTERM_HI    11
`define MRC_WTERM_LO    9
`define MRC_UI_NORMAL   4'h8
`define MRC_UI_CRC      4'ha
`define MRC_CK_NORMAL   3'h4
`define MRC_CK_CRC      3'h5
`define MRC_TEMP_MS     32
`define MRC_CLK_MHZ     50
`define MRC_TEMP_CYC    (`MRC_TEMP_MS * 1000 * `MRC_CLK_MHZ)
`endif

// File: hw/mrc_pkg.sv
// Types shared by the mode register three block.
// Assumes mrc_defines.svh holds all numbers.
package mrc_pkg;
    typedef struct packed {
        logic        ck;
        logic        cs_n;
        logic        act_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic [1:0]  bg;
        logic [1:0]  ba;
        logic [17:0] addr;
        logic        dq0;
        logic [1:0]  temp;
    } mrc_pins_t;
    typedef enum logic [1:0] {
        MRC_FMT_SERIAL, MRC_FMT_PARALLEL, MRC_FMT_STAGGER, MRC_FMT_RSVD
    } mrc_fmt_t;
    typedef enum logic [2:0] {
        MRC_REF_1X, MRC_REF_2X, MRC_REF_4X, MRC_REF_OTF12, MRC_REF_OTF14,
        MRC_REF_RSVD
    } mrc_ref_t;
    typedef enum logic [2:0] {
        MRC_TERM_OFF, MRC_TERM_120, MRC_TERM_240, MRC_TERM_HIZ,
        MRC_TERM_80, MRC_TERM_RSVD
    } mrc_term_t;
    typedef struct packed {
        mrc_pins_t       s1;
        mrc_pins_t       s2;
        logic            ck_prev;
        logic [21:0]     mr3;
        logic [21:0]     mr2;
        logic [2:0]      wr_left;
        logic [20:0]     temp_tmr;
        logic [1:0]      temp;
        logic [3:0][7:0] pat;
        logic            rd_valid;
        logic [7:0]      rd_data;
        logic            pda_drop;
    } mrc_state_t;
endpackage

// File: hw/mrc_mode3.sv
// Mode register three decode with pattern readout store and write
// termination control. Assumes command pins come from the controller clock
// domain and are synchronised here; err_frame is on core_clk.
`timescale 1ns/1ps
`include "mrc_defines.svh"
module mrc_mode3
    import mrc_pkg::*;
#(
    parameter int TEMP_CYC = `MRC_TEMP_CYC
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Command/address pins, controller domain
    input  wire mrc_pins_t   pins,
    // Device-side context
    input  wire logic        write_level,
    input  wire logic [2:0]  nominal_term,
    input  wire logic [31:0] err_frame,
    // Decoded configuration
    output logic [21:0]      mode_config_three,
    output mrc_fmt_t         read_format,
    output logic [2:0]       crc_mask_write_latency,
    output mrc_ref_t         refresh_mode,
    output logic             temp_report_en,
    output logic             per_device_en,
    output logic             gear_down,
    output logic             pattern_mode,
    output logic [1:0]       pattern_page,
    output logic             crc_en,
    output logic [3:0]       burst_ui,
    output mrc_term_t        write_termination,
    // Termination in use
    output logic [2:0]       term_sel,
    output logic             term_is_write,
    // Pattern readout
    output logic             rd_valid,
    output logic [7:0]       rd_data,
    output logic             cmd_dropped
);
    mrc_state_t st;
    mrc_state_t next_st;

    logic        ck_rise;
    logic        accept;
    logic        mrs_hit;
    logic        wr_hit;
    logic        rd_hit;
    logic [2:0]  sel;
    logic [21:0] word;

    function automatic logic is_cmd(mrc_pins_t p, logic ras, logic cas,
                                    logic we);
        is_cmd = !p.cs_n && p.act_n && p.ras_n == ras && p.cas_n == cas &&
                 p.we_n == we;
    endfunction

    function automatic logic [7:0] pick(mrc_state_t s, logic [31:0] ef);
        logic [1:0] loc;
        logic       up;
        loc  = s.s2.addr[1:0];
        up   = s.s2.addr[2];
        pick = 8'h00;
        case (s.mr3[`MRC_PAGE_HI:`MRC_PAGE_LO])
            2'h0: pick = s.pat[loc];
            2'h1: pick = ef[8*loc +: 8];
            2'h2: begin
                case (loc)
                    2'h0: pick = {3'h0, s.temp, 3'h0};
                    2'h1: pick = up ? s.mr3[15:8] : s.mr3[7:0];
                    2'h2: pick = up ? s.mr2[15:8] : s.mr2[7:0];
                    default: pick = up ? {2'h0, s.mr3[21:16]} :
                                         {2'h0, s.mr2[21:16]};
                endcase
            end
            default: pick = 8'h00;
        endcase
    endfunction

    assign ck_rise = st.s2.ck && !st.ck_prev;
    // Per-device mode: only a device with DQ0 low takes the command
    assign accept  = !st.mr3[`MRC_PDA_EN] || !st.s2.dq0;
    assign mrs_hit = ck_rise && is_cmd(st.s2, 1'b0, 1'b0, 1'b0);
    assign wr_hit  = ck_rise && is_cmd(st.s2, 1'b1, 1'b0, 1'b0);
    assign rd_hit  = ck_rise && is_cmd(st.s2, 1'b1, 1'b0, 1'b1);
    assign sel     = {st.s2.bg[0], st.s2.ba};
    // Pins 16:14 carry the strobes, so those bits are stored as zero
    assign word    = {st.s2.bg, st.s2.ba, st.s2.addr[17], 3'h0,
                      st.s2.addr[13:0]};

    always_comb begin
        next_st = st;
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.ck_prev = st.s2.ck;
        next_st.rd_valid = 1'b0;
        next_st.pda_drop = 1'b0;
        if (mrs_hit) begin
            if (!accept)
                next_st.pda_drop = 1'b1;
            else if (sel == `MRC_SEL_MR3)
                next_st.mr3 = word;
            else if (sel == `MRC_SEL_MR2)
                next_st.mr2 = word;
        end
        if (wr_hit && accept) begin
            // Window in controller clocks: 4 for BL8, 5 with CRC
            next_st.wr_left = st.mr2[`MRC_CRC_EN] ? `MRC_CK_CRC :
                                                    `MRC_CK_NORMAL;
            if (st.mr3[`MRC_MPR_EN] &&
                st.mr3[`MRC_PAGE_HI:`MRC_PAGE_LO] == 2'h0)
                next_st.pat[st.s2.addr[1:0]] = st.s2.addr[7:0];
        end else if (ck_rise && st.wr_left != 3'h0) begin
            next_st.wr_left = st.wr_left - 3'h1;
        end
        if (rd_hit && accept && st.mr3[`MRC_MPR_EN]) begin
            next_st.rd_valid = 1'b1;
            next_st.rd_data = pick(st, err_frame);
        end
        // First sample is taken as soon as reporting is enabled
        if (!st.mr3[`MRC_TEMP_EN]) begin
            next_st.temp_tmr = 21'h0;
        end else if (st.temp_tmr == 21'h0) begin
            next_st.temp = st.s2.temp;
            next_st.temp_tmr = 21'(TEMP_CYC - 1);
        end else begin
            next_st.temp_tmr = st.temp_tmr - 21'h1;
        end
    end

    // Reset clears everything but the clock taps, which load high; the controller must re-initialise
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            // Link clock taps read high, so a pin already high is no edge
            st.s1.ck <= 1'b1;
            st.s2.ck <= 1'b1;
            st.ck_prev <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign mode_config_three = st.mr3;
    assign read_format = mrc_fmt_t'(st.mr3[`MRC_FMT_HI:`MRC_FMT_LO]);
    always_comb begin
        case (st.mr3[`MRC_WCL_HI:`MRC_WCL_LO])
            2'h0:    crc_mask_write_latency = 3'h4;
            2'h1:    crc_mask_write_latency = 3'h5;
            2'h2:    crc_mask_write_latency = 3'h6;
            default: crc_mask_write_latency = 3'h0;
        endcase
        case (st.mr3[`MRC_FGR_HI:`MRC_FGR_LO])
            3'h0:    refresh_mode = MRC_REF_1X;
            3'h1:    refresh_mode = MRC_REF_2X;
            3'h2:    refresh_mode = MRC_REF_4X;
            3'h5:    refresh_mode = MRC_REF_OTF12;
            3'h6:    refresh_mode = MRC_REF_OTF14;
            default: refresh_mode = MRC_REF_RSVD;
        endcase
        case (st.mr2[`MRC_WTERM_HI:`MRC_WTERM_LO])
            3'h0:    write_termination = MRC_TERM_OFF;
            3'h1:    write_termination = MRC_TERM_120;
            3'h2:    write_termination = MRC_TERM_240;
            3'h3:    write_termination = MRC_TERM_HIZ;
            3'h4:    write_termination = MRC_TERM_80;
            default: write_termination = MRC_TERM_RSVD;
        endcase
    end
    assign temp_report_en = st.mr3[`MRC_TEMP_EN];
    assign per_device_en = st.mr3[`MRC_PDA_EN];
    assign gear_down = st.mr3[`MRC_GEAR];
    assign pattern_mode = st.mr3[`MRC_MPR_EN];
    assign pattern_page = st.mr3[`MRC_PAGE_HI:`MRC_PAGE_LO];
    assign crc_en = st.mr2[`MRC_CRC_EN];
    assign burst_ui = crc_en ? `MRC_UI_CRC : `MRC_UI_NORMAL;
    // Leveling uses nominal only; a disabled write code leaves it alone
    assign term_is_write = st.wr_left != 3'h0 && !write_level &&
                           st.mr2[`MRC_WTERM_HI:`MRC_WTERM_LO] != 3'h0;
    assign term_sel = term_is_write ? st.mr2[`MRC_WTERM_HI:`MRC_WTERM_LO] :
                      nominal_term;
    assign rd_valid = st.rd_valid;
    assign rd_data = st.rd_data;
    assign cmd_dropped = st.pda_drop;

    // Register load and hold
    a_mr3_load: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        mrs_hit && accept && sel == `MRC_SEL_MR3 |=>
        mode_config_three == $past(word))
        else $error("register three not loaded");

    a_mr3_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !(mrs_hit && accept && sel == `MRC_SEL_MR3) |=>
        $stable(mode_config_three))
        else $error("register three changed without load");

    a_pda_block: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        mrs_hit && per_device_en && st.s2.dq0 |=>
        cmd_dropped && $stable(mode_config_three))
        else $error("masked device took a mode-set");

    a_pda_read: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rd_hit && per_device_en && st.s2.dq0 |=> !rd_valid)
        else $error("masked device answered a read");

    // No disable here, so the cleared state is seen while reset holds
    a_reset_clear: assert property (
        @(posedge core_clk)
        !rst_n ##1 !rst_n |-> mode_config_three == 22'h0 && !pattern_mode)
        else $error("reset left register three set");

    // Field decodes, held against fixed codes
    a_burst_len: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        burst_ui == (st.mr2[12] ? 4'ha : 4'h8))
        else $error("burst length mismatch");

    a_wcl_map: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        st.mr3[10:9] != 2'h3 |->
        crc_mask_write_latency == 3'h4 + {1'b0, st.mr3[10:9]})
        else $error("write latency decode wrong");

    a_fmt_map: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        mode_config_three[12:11] == 2'h2 |-> read_format == MRC_FMT_STAGGER)
        else $error("read format decode wrong");

    a_ref_otf: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        mode_config_three[8:6] == 3'h5 |-> refresh_mode == MRC_REF_OTF12)
        else $error("on-the-fly refresh decode wrong");

    a_ref_rsvd: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        mode_config_three[8:6] inside {3'h3, 3'h4, 3'h7} |->
        refresh_mode == MRC_REF_RSVD)
        else $error("reserved refresh code not flagged");

    a_wterm_80: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        st.mr2[11:9] == 3'h4 |-> write_termination == MRC_TERM_80)
        else $error("write termination decode wrong");

    a_gear_map: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(gear_down) |-> $past(mrs_hit && accept && sel == `MRC_SEL_MR3))
        else $error("gear-down set without mode-set");

    // Termination in use
    a_wl_nominal: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        write_level |-> term_sel == nominal_term && !term_is_write)
        else $error("write termination used in leveling");

    a_wr_term: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_hit && accept && st.mr2[11:9] != 3'h0 && !write_level ##1
        !write_level |-> term_is_write && term_sel == st.mr2[11:9])
        else $error("write termination not applied");

    // Pattern readout
    a_rd_redirect: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rd_hit && accept |=> rd_valid == $past(pattern_mode))
        else $error("read not redirected correctly");

    a_no_array: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !pattern_mode |=> !rd_valid)
        else $error("read answered outside readout mode");

    a_page0_store: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_hit && accept && pattern_mode && pattern_page == 2'h0 |=>
        st.pat[$past(st.s2.addr[1:0])] == $past(st.s2.addr[7:0]))
        else $error("pattern write not stored");

    a_page1_err: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rd_hit && accept && pattern_mode && pattern_page == 2'h1 &&
        st.s2.addr[1:0] == 2'h0 |=> rd_data == $past(err_frame[7:0]))
        else $error("error frame byte not returned");

    a_temp_loc: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rd_hit && accept && pattern_mode && pattern_page == 2'h2 &&
        st.s2.addr[1:0] == 2'h0 |=>
        rd_data == {3'h0, $past(st.temp), 3'h0})
        else $error("temperature status not at bits 4:3");

    a_half_sel: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rd_hit && accept && pattern_mode && pattern_page == 2'h2 &&
        st.s2.addr[2:0] == 3'h5 |=> rd_data == mode_config_three[15:8])
        else $error("upper half of register three not returned");

    a_page3_zero: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        rd_hit && accept && pattern_mode && pattern_page == 2'h3 |=>
        rd_data == 8'h00)
        else $error("restricted page returned data");

    a_temp_fresh: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        temp_report_en && st.temp_tmr == 21'h0 |=>
        st.temp == $past(st.s2.temp) &&
        st.temp_tmr == 21'(TEMP_CYC - 1))
        else $error("temperature status not refreshed");

    // Main scenarios
    c_pattern_read: cover property (@(posedge core_clk) disable iff (!rst_n)
        pattern_mode && rd_valid);
    c_crc_write: cover property (@(posedge core_clk) disable iff (!rst_n)
        crc_en && term_is_write);
    c_temp_read: cover property (@(posedge core_clk) disable iff (!rst_n)
        rd_valid && pattern_page == 2'h2 && temp_report_en);
    c_pda_drop: cover property (@(posedge core_clk) disable iff (!rst_n)
        cmd_dropped);
    c_level_write: cover property (@(posedge core_clk) disable iff (!rst_n)
        write_level && wr_hit);
endmodule

// File: test/mrc_ctl_model.sv
// Controller model: issues one framed command per controller clock.
// Assumes core_clk from the bench; pins move 1 ns after its rising edges.
`timescale 1ns/1ps
module mrc_ctl_model
    import mrc_pkg::*;
(
    // Clock and sensor level
    input  wire logic       core_clk,
    input  wire logic [1:0] sensor_temp,
    // Device pins
    output mrc_pins_t       pins
);
    initial begin
        pins = '0;
        pins.cs_n = 1'b1;
    end
    // k: 0 mode-set, 1 write, 2 read, 3 deselect; ck stops between
    task automatic cmd(input int k, input logic [3:0] sel,
                       input logic [17:0] a, input logic dq);
        @(posedge core_clk);
        #1;
        pins.ck = 1'b0;
        pins.temp = sensor_temp;
        pins.cs_n = k == 3;
        pins.act_n = 1'b1;
        pins.ras_n = k == 1 || k == 2;
        pins.cas_n = k == 3;
        pins.we_n = k >= 2;
        {pins.bg, pins.ba} = sel;
        // A released address never shows its last value
        pins.addr = k == 3 ? ~pins.addr : a;
        pins.dq0 = dq;
        repeat (4) @(posedge core_clk);
        #1;
        pins.ck = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
    endtask
endmodule

// File: test/mrc_mode3_tb.sv
// Bench for mrc_mode3: a controller model drives the pins, a model here
// predicts every result. Assumes a 50 MHz core clock.
`timescale 1ns/1ps
module mrc_mode3_tb;
    import mrc_pkg::*;
    localparam int TCYC = 20;
    logic        core_clk, rst_n, write_level, crc_en, term_is_write;
    logic        temp_report_en, per_device_en, gear_down, pattern_mode;
    logic        rd_valid, cmd_dropped;
    logic [1:0]  sensor_temp, pattern_page;
    logic [2:0]  nominal_term, crc_mask_write_latency, term_sel;
    logic [3:0]  burst_ui;
    logic [7:0]  rd_data, rd_last;
    logic [21:0] mode_config_three;
    logic [31:0] err_frame;
    mrc_pins_t   pins;
    mrc_fmt_t    read_format;
    mrc_ref_t    refresh_mode;
    mrc_term_t   write_termination;
    int          seed = 32'h2d2f;
    int          n_mismatch = 0, n_tests = 0, n_rd = 0, n_drop = 0;
    int          e3, e2, n, pat[4];
    int          fg[5] = '{0, 1, 2, 5, 6};

    mrc_ctl_model ctl (.core_clk(core_clk), .sensor_temp(sensor_temp),
                       .pins(pins));
    mrc_mode3 #(.TEMP_CYC(TCYC)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .pins(pins),
        .write_level(write_level), .nominal_term(nominal_term),
        .err_frame(err_frame), .mode_config_three(mode_config_three),
        .read_format(read_format), .refresh_mode(refresh_mode),
        .crc_mask_write_latency(crc_mask_write_latency),
        .temp_report_en(temp_report_en), .per_device_en(per_device_en),
        .gear_down(gear_down), .pattern_mode(pattern_mode),
        .pattern_page(pattern_page), .crc_en(crc_en), .burst_ui(burst_ui),
        .write_termination(write_termination), .term_sel(term_sel),
        .term_is_write(term_is_write), .rd_valid(rd_valid),
        .rd_data(rd_data), .cmd_dropped(cmd_dropped));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (rd_valid === 1'b1) begin
            n_rd++;
            rd_last = rd_data;
        end
        if (cmd_dropped === 1'b1) n_drop++;
    end

    task automatic chk(input string s, input logic [31:0] seen,
                       input logic [31:0] expv);
        n_tests++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", s, expv, seen);
        end
    endtask
    task automatic mrs(input logic [2:0] r, input logic [21:0] v,
                       input logic dq);
        ctl.cmd(0, {1'b0, r}, {v[17], 3'h0, v[13:0]}, dq);
        // Model: select bits are stored, a masked device keeps its value
        if (!(dq && e3[4]) && r == 3'h3)
            e3 = int'(v & 22'h023fff) | 32'hc0000;
        if (!(dq && e3[4]) && r == 3'h2)
            e2 = int'(v & 22'h023fff) | 32'h80000;
    endtask
    task automatic rd(input int loc, input int expv);
        int n0;
        n0 = n_rd;
        ctl.cmd(2, 4'h0, 18'(loc), 1'b0);
        chk("reads", n_rd, n0 + 1);
        chk("rd_data", 32'(rd_last), expv);
    endtask
    task automatic cfg();
        int f;
        int w;
        logic [5:0] fl;
        f = e3 >> 6 & 7;
        w = 4 + (e3 >> 9 & 3);
        fl = {temp_report_en, per_device_en, gear_down, pattern_mode,
              pattern_page};
        chk("config", 32'(mode_config_three), e3);
        chk("format", 32'(read_format), e3 >> 11 & 3);
        chk("latency", 32'(crc_mask_write_latency), w);
        chk("refresh", 32'(refresh_mode), f > 4 ? f - 2 : f);
        chk("flags", 32'(fl), e3 & 32'h3f);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        rst_n = 1'b0;
        write_level = 1'b0;
        sensor_temp = 2'h2;
        nominal_term = 3'($random(seed));
        err_frame = $random(seed);
        e3 = 0;
        e2 = 0;
        repeat (20) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk("burst_ui", 32'(burst_ui), 8);
        chk("term_sel", 32'(term_sel), 32'(nominal_term));
        cfg();
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            // Only legal codes go out
            // Latency codes step as for rising data rates
            e3 = (i % 3) << 11 | (i % 3) << 9 | fg[i] << 6;
            e3 = e3 | ({$random(seed)} & 32'h3b);
            mrs(3'h3, 22'(e3), 1'b0);
            cfg();
            mrs(3'h1, 22'($random(seed)), 1'b0);
            cfg();
        end
        for (int t = 0; t < 5; t++) begin
            mrs(3'h2, 22'((t & 1) << 12 | t << 9), 1'b0);
            chk("crc_en", 32'(crc_en), t & 1);
            chk("burst_ui", 32'(burst_ui), (t & 1) ? 10 : 8);
            chk("wterm", 32'(write_termination), t);
        end
        for (int c = 0; c < 2; c++) begin
            e2 = c << 12 | 1 << 9;
            mrs(3'h2, 22'(e2), 1'b0);
            ctl.cmd(1, 4'h0, 18'h0, 1'b0);
            chk("term_sel", 32'(term_sel), 1);
            for (n = 1; n <= 4 + c; n++) begin
                ctl.cmd(3, 4'h0, 18'h0, 1'b0);
                chk("window", 32'(term_is_write), n < 4 + c);
            end
            chk("term_sel", 32'(term_sel), 32'(nominal_term));
        end
        write_level = 1'b1;
        ctl.cmd(1, 4'h0, 18'h0, 1'b0);
        chk("term_sel", 32'(term_sel), 32'(nominal_term));
        write_level = 1'b0;
        $display("test termination done");
        n = n_rd;
        ctl.cmd(2, 4'h0, 18'h0, 1'b0);
        chk("reads", n_rd, n);
        // The model never opens a row, so banks are idle
        e3 = 4;
        mrs(3'h3, 22'(e3), 1'b0);
        // Only reads, writes and mode-sets in this mode
        for (int l = 0; l < 4; l++) begin
            pat[l] = {$random(seed)} & 32'hfc | l;
            ctl.cmd(1, 4'h0, 18'(pat[l]), 1'b0);
        end
        for (int l = 0; l < 4; l++) rd(l, pat[l]);
        e3 = 5;
        mrs(3'h3, 22'(e3), 1'b0);
        for (int l = 0; l < 4; l++) rd(l, err_frame >> 8 * l & 8'hff);
        e3 = 32'h26;
        mrs(3'h3, 22'(e3), 1'b0);
        for (int t = 2; t >= 1; t--) begin
            sensor_temp = 2'(t);
            ctl.cmd(3, 4'h0, 18'h0, 1'b0);
            repeat (TCYC + 4) @(posedge core_clk);
            rd(0, t << 3);
        end
        rd(1, e3 & 8'hff);
        rd(5, e3 >> 8 & 8'hff);
        rd(2, e2 & 8'hff);
        rd(6, e2 >> 8 & 8'hff);
        rd(7, e3 >> 16);
        rd(3, e2 >> 16);
        $display("test pattern done");
        e3 = 32'h10;
        mrs(3'h3, 22'(e3), 1'b0);
        n = n_drop;
        mrs(3'h3, 22'h8, 1'b1);
        chk("dropped", n_drop, n + 1);
        cfg();
        e3 = 4;
        mrs(3'h3, 22'(e3), 1'b0);
        rst_n = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1'b1;
        e3 = 0;
        e2 = 0;
        repeat (3) @(posedge core_clk);
        #1;
        cfg();
        // Register three is loaded again after the reset
        e3 = 1;
        mrs(3'h3, 22'(e3), 1'b0);
        cfg();
        $display("test device and reset done");
        stop_test();
    end
endmodule
